/* pcf_pkg.sv */
// constants and types shared by the pulse counter input filter
package pcf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and timebase
	localparam logic [31:0] CLOCK_PERIOD_NS = 32'h0000_0032;
	localparam logic [31:0] TICK_NS = 32'h000F_4240;
	localparam logic [31:0] TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int TIMER_W = 23;
	localparam int HOLD_W = 16;
	localparam int PRESC_W = 14;
	localparam int INC_W = 15;
	localparam int CNT_W = 32;

	////////////////////////////////////////////////////////////////////////////
	// debounce intervals in milliseconds
	localparam logic [7:0] DEB_MS_10 = 8'h0A;
	localparam logic [7:0] DEB_MS_20 = 8'h14;
	localparam logic [7:0] DEB_MS_30 = 8'h1E;
	localparam logic [7:0] DEB_MS_50 = 8'h32;
	localparam logic [7:0] DEB_MS_70 = 8'h46;
	localparam logic [7:0] DEB_MS_100 = 8'h64;
	localparam logic [7:0] DEB_MS_150 = 8'h96;

	////////////////////////////////////////////////////////////////////////////
	// hold time unit of 0.1 s in milliseconds, and defaults
	localparam logic [6:0] HOLD_UNIT_MS = 7'h64;
	localparam logic [15:0] HOLD_DEFAULT = 16'h000A;
	localparam logic [13:0] PRESC_DEFAULT = 14'h0001;
	localparam logic [13:0] PRESC_MAX = 14'h2710;
	localparam logic signed [14:0] INC_DEFAULT = 15'sh0001;
	localparam logic signed [14:0] INC_MAX = 15'sh2710;

	////////////////////////////////////////////////////////////////////////////
	// counter type ranges and limit defaults
	localparam logic signed [31:0] LIM1_DEFAULT = 32'sh0000_0000;
	localparam logic signed [31:0] S8_MIN = 32'shFFFF_FF80;
	localparam logic signed [31:0] S8_MAX = 32'sh0000_007F;
	localparam logic signed [31:0] U8_MAX = 32'sh0000_00FF;
	localparam logic signed [31:0] S16_MIN = 32'shFFFF_8000;
	localparam logic signed [31:0] S16_MAX = 32'sh0000_7FFF;
	localparam logic signed [31:0] U16_MAX = 32'sh0000_FFFF;
	localparam logic signed [31:0] S32_MIN = 32'sh8000_0000;
	localparam logic signed [31:0] S32_MAX = 32'sh7FFF_FFFF;
	localparam logic signed [31:0] S32_LIM2_DEFAULT = 32'sh7FFE_B940;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {DT_S8, DT_U8, DT_S16, DT_U16, DT_S32} pcf_dtype_t;
	typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} pcf_edge_t;

	typedef struct packed {
		logic [2:0] debounce_sel;
		logic min_sig_en;
		logic [15:0] rise_hold;
		logic [15:0] fall_hold;
		logic adapt_en;
		pcf_edge_t edge_sel;
		logic [13:0] pulses_per_step;
		logic signed [14:0] step_inc;
		pcf_dtype_t dtype;
		logic signed [31:0] limit1;
		logic signed [31:0] limit2;
		logic limit2_dflt;
	} pcf_cfg_t;

	typedef struct packed {
		logic level;
		logic rise_event;
		logic fall_event;
		logic in_pulse;
		logic step;
		logic signed [31:0] count;
	} pcf_status_t;

endpackage

/* pcf_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pcf_sync (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// raw and clean level
	input wire logic i_raw,
	output logic o_level
);
	logic meta_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			meta_q <= i_raw;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	// level moves only when the second and third stages agree
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= 1'b0;
		end else if (s2_q == s3_q) begin
			o_level <= s3_q;
		end
	end
endmodule

/* pcf_interval_timer.sv */
// restartable down timer counted in timebase ticks
`timescale 1ns/10ps
module pcf_interval_timer #(
	parameter int W = 23
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// control
	input wire logic i_tick,
	input wire logic i_start,
	input wire logic [W-1:0] i_load,
	// state
	output logic o_busy,
	output logic o_expire
);
	logic [W-1:0] remain_q;

	// a start always restarts from the full load, even while busy
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			remain_q <= '0;
			o_busy <= 1'b0;
			o_expire <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			if (i_start) begin
				remain_q <= (i_load == '0) ? W'(1) : i_load;
				o_busy <= 1'b1;
			end else if (o_busy && i_tick) begin
				remain_q <= remain_q - W'(1);
				if (remain_q == W'(1)) begin
					o_busy <= 1'b0;
					o_expire <= 1'b1;
				end
			end
		end
	end
endmodule

/* pcf_counter_channel.sv */
// binary input channel in counter mode: filter, pulse shaping, prescaler, wrap counter
//
// Functional notes
// (RL1) debounce interval selectable: 10, 20, 30, 50, 70, 100 or 150 ms.
// (RL2) idle debounce: act on an edge at once and start the interval.
// (RL3) while debounce runs, the input is not evaluated; edges are dropped. Here a level still changed when the interval ends is reported then.
// (RL4) rising-edge hold time 1..65535 units of 0.1 s, default 10.
// (RL5) falling-edge hold time is a separate setting, same range and unit.
// (RL6) with hold time on, an edge starts its timer and reports nothing yet.
// (RL7) an edge during the hold time restarts the hold timer from zero.
// (RL8) report an edge only when its hold time ends without another edge.
// (RL9) counter type: signed/unsigned 8 bit, signed/unsigned 16 bit, signed 32 bit.
// (RL10) a step beyond the limit in counting direction loads the opposite limit.
// (RL11) a full cycle takes span plus one steps; the wrap is one step.
// (RL12) software must program two different limit values.
// (RL13) limits accepted in either order; larger and smaller found in hardware.
// (RL14) first limit defaults to zero for every type.
// (RL15) second limit default per type: 127, 255, 32767, 65535, 2147400000.
// (RL16) default mode adds exactly one per rising edge.
// (RL17) adapted mode pulses on rising, falling or both edges.
// (RL18) one counter step per N input pulses, N 1..10000, default 1.
// (RL19) each step adds a signed increment of -10000..10000, default 1.
// (RL20) increment sign sets direction: negative down, positive up.
// (RL21) while blocked, the counter takes no pulses.
// (RL22) intervals count a 1 ms tick; counter clears to first limit on reset.
`timescale 1ns/10ps
module pcf_counter_channel #(
	parameter logic [31:0] TICK_CYCLES = pcf_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// contact input
	input wire logic i_contact,
	// configuration and control
	input wire pcf_pkg::pcf_cfg_t i_cfg,
	input wire logic i_block,
	input wire logic i_counter_clear,
	// status
	output pcf_pkg::pcf_status_t o_status
);

	////////////////////////////////////////////////////////////////////////////
	// synchronised contact level
	logic level;
	logic level_prev_q;

	pcf_sync u_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_raw(i_contact),
		.o_level(level)
	);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_prev_q <= 1'b0;
		end else begin
			level_prev_q <= level;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// millisecond timebase
	logic [31:0] tick_cnt_q;
	logic tick_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= TICK_CYCLES - 32'h0000_0001) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b1; // [RL22]
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interval lengths in ticks
	logic [7:0] deb_ms;
	logic [15:0] hold_units;
	logic [pcf_pkg::TIMER_W-1:0] deb_ticks;
	logic [pcf_pkg::TIMER_W-1:0] hold_ticks;

	always_comb begin
		unique case (i_cfg.debounce_sel) // [RL1]
			3'h0: deb_ms = pcf_pkg::DEB_MS_10;
			3'h1: deb_ms = pcf_pkg::DEB_MS_20;
			3'h2: deb_ms = pcf_pkg::DEB_MS_30;
			3'h3: deb_ms = pcf_pkg::DEB_MS_50;
			3'h4: deb_ms = pcf_pkg::DEB_MS_70;
			3'h5: deb_ms = pcf_pkg::DEB_MS_100;
			default: deb_ms = pcf_pkg::DEB_MS_150;
		endcase
	end

	// hold time chosen by the direction of the new level
	always_comb begin
		hold_units = level ? i_cfg.rise_hold : i_cfg.fall_hold; // [RL4] [RL5]
		if (hold_units == 16'h0000) begin
			hold_units = 16'h0001;
		end
	end

	assign deb_ticks = pcf_pkg::TIMER_W'(deb_ms);
	assign hold_ticks = pcf_pkg::TIMER_W'(hold_units) * pcf_pkg::TIMER_W'(pcf_pkg::HOLD_UNIT_MS);

	////////////////////////////////////////////////////////////////////////////
	// edge filter state machine
	typedef enum logic [1:0] {FS_IDLE, FS_DEBOUNCE, FS_HOLD} pcf_filt_state_t;

	pcf_filt_state_t state_q;
	logic filt_q;
	logic rise_ev_q;
	logic fall_ev_q;
	logic tmr_start;
	logic [pcf_pkg::TIMER_W-1:0] tmr_load;
	logic tmr_busy;
	logic tmr_expire;
	logic level_changed;
	logic accept;

	assign level_changed = (level != level_prev_q);

	pcf_interval_timer #(
		.W(pcf_pkg::TIMER_W)
	) u_timer (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_tick(tick_q),
		.i_start(tmr_start),
		.i_load(tmr_load),
		.o_busy(tmr_busy),
		.o_expire(tmr_expire)
	);

	always_comb begin
		tmr_start = 1'b0;
		tmr_load = deb_ticks;
		accept = 1'b0;
		unique case (state_q)
			FS_IDLE: begin
				if (!i_cfg.min_sig_en && level != filt_q) begin
					accept = 1'b1; // [RL2]
					tmr_start = 1'b1;
				end else if (i_cfg.min_sig_en && level_changed) begin
					tmr_start = 1'b1; // [RL6]
					tmr_load = hold_ticks;
				end
			end
			FS_DEBOUNCE: begin
				accept = 1'b0; // [RL3]
			end
			FS_HOLD: begin
				if (level_changed) begin
					tmr_start = 1'b1; // [RL7]
					tmr_load = hold_ticks;
				end else if (tmr_expire && level != filt_q) begin
					accept = 1'b1; // [RL8]
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= FS_IDLE;
		end else begin
			unique case (state_q)
				FS_IDLE: begin
					if (tmr_start) begin
						state_q <= i_cfg.min_sig_en ? FS_HOLD : FS_DEBOUNCE;
					end
				end
				FS_DEBOUNCE: begin
					if (!tmr_busy) begin
						state_q <= FS_IDLE; // [RL3]
					end
				end
				FS_HOLD: begin
					if (!tmr_start && (tmr_expire || !tmr_busy)) begin
						state_q <= FS_IDLE; // [RL8]
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			filt_q <= 1'b0;
			rise_ev_q <= 1'b0;
			fall_ev_q <= 1'b0;
		end else begin
			rise_ev_q <= accept && level;
			fall_ev_q <= accept && !level;
			if (accept) begin
				filt_q <= level;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input pulse shaping
	logic pulse;
	logic pulse_q;

	always_comb begin
		if (!i_cfg.adapt_en) begin
			pulse = rise_ev_q; // [RL16]
		end else begin
			unique case (i_cfg.edge_sel) // [RL17]
				pcf_pkg::EDGE_RISE: pulse = rise_ev_q;
				pcf_pkg::EDGE_FALL: pulse = fall_ev_q;
				pcf_pkg::EDGE_BOTH: pulse = rise_ev_q || fall_ev_q;
				default: pulse = 1'b0;
			endcase
		end
		if (i_block) begin
			pulse = 1'b0; // [RL21]
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// prescaler
	logic [pcf_pkg::PRESC_W-1:0] presc_q;
	logic [pcf_pkg::PRESC_W-1:0] presc_n;
	logic step;
	logic step_q;

	always_comb begin
		presc_n = i_cfg.adapt_en ? i_cfg.pulses_per_step : pcf_pkg::PRESC_DEFAULT;
		if (presc_n == '0) begin
			presc_n = pcf_pkg::PRESC_DEFAULT;
		end else if (presc_n > pcf_pkg::PRESC_MAX) begin
			presc_n = pcf_pkg::PRESC_MAX;
		end
	end

	assign step = pulse && (presc_q + pcf_pkg::PRESC_W'(1) >= presc_n); // [RL18]

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc_q <= '0;
			step_q <= 1'b0;
		end else begin
			step_q <= step;
			if (i_counter_clear) begin
				presc_q <= '0;
			end else if (step) begin
				presc_q <= '0; // [RL18]
			end else if (pulse) begin
				presc_q <= presc_q + pcf_pkg::PRESC_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// limits: type range, default, ordering
	logic signed [31:0] type_min;
	logic signed [31:0] type_max;
	logic signed [31:0] lim2_dflt;
	logic signed [31:0] lim2;
	logic signed [31:0] lim_hi;
	logic signed [31:0] lim_lo;

	always_comb begin
		unique case (i_cfg.dtype) // [RL9]
			pcf_pkg::DT_S8: begin
				type_min = pcf_pkg::S8_MIN;
				type_max = pcf_pkg::S8_MAX;
				lim2_dflt = pcf_pkg::S8_MAX; // [RL15]
			end
			pcf_pkg::DT_U8: begin
				type_min = pcf_pkg::LIM1_DEFAULT;
				type_max = pcf_pkg::U8_MAX;
				lim2_dflt = pcf_pkg::U8_MAX; // [RL15]
			end
			pcf_pkg::DT_S16: begin
				type_min = pcf_pkg::S16_MIN;
				type_max = pcf_pkg::S16_MAX;
				lim2_dflt = pcf_pkg::S16_MAX; // [RL15]
			end
			pcf_pkg::DT_U16: begin
				type_min = pcf_pkg::LIM1_DEFAULT;
				type_max = pcf_pkg::U16_MAX;
				lim2_dflt = pcf_pkg::U16_MAX; // [RL15]
			end
			default: begin
				type_min = pcf_pkg::S32_MIN;
				type_max = pcf_pkg::S32_MAX;
				lim2_dflt = pcf_pkg::S32_LIM2_DEFAULT; // [RL15]
			end
		endcase
	end

	// equal limits are left to software and give a counter stuck at that value
	always_comb begin
		lim2 = i_cfg.limit2_dflt ? lim2_dflt : i_cfg.limit2;
		if (i_cfg.limit1 > lim2) begin
			lim_hi = i_cfg.limit1; // [RL13] [RL12]
			lim_lo = lim2;
		end else begin
			lim_hi = lim2;
			lim_lo = i_cfg.limit1;
		end
		if (lim_hi > type_max) begin
			lim_hi = type_max; // [RL9]
		end
		if (lim_lo < type_min) begin
			lim_lo = type_min;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// main counter with circular wrap
	logic signed [31:0] count_q;
	logic signed [14:0] inc;
	logic signed [33:0] sum;
	logic init_q;

	always_comb begin
		inc = i_cfg.adapt_en ? i_cfg.step_inc : pcf_pkg::INC_DEFAULT;
		if (inc > pcf_pkg::INC_MAX) begin
			inc = pcf_pkg::INC_MAX;
		end else if (inc < -pcf_pkg::INC_MAX) begin
			inc = -pcf_pkg::INC_MAX;
		end
	end

	assign sum = 34'(count_q) + 34'(inc); // [RL19]

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			init_q <= 1'b0;
		end else begin
			init_q <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_q <= pcf_pkg::LIM1_DEFAULT; // [RL14]
		end else if (!init_q || i_counter_clear) begin
			count_q <= i_cfg.limit1; // [RL22]
		end else if (step) begin
			if (inc > 15'sh0000 && sum > 34'(lim_hi)) begin
				count_q <= lim_lo; // [RL10] [RL11] [RL20]
			end else if (inc < 15'sh0000 && sum < 34'(lim_lo)) begin
				count_q <= lim_hi; // [RL10] [RL11] [RL20]
			end else begin
				count_q <= 32'(sum);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status outputs
	assign o_status.level = filt_q;
	assign o_status.rise_event = rise_ev_q;
	assign o_status.fall_event = fall_ev_q;
	assign o_status.in_pulse = pulse_q;
	assign o_status.step = step_q;
	assign o_status.count = count_q;

endmodule

/* pcf_counter_channel_sva.sv */
// checker for the pulse counter channel ports
`timescale 1ns/10ps
module pcf_counter_channel_sva #(
	parameter logic [31:0] TICK_CYCLES = 32'h0000_0004
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// inputs and status
	input wire logic i_contact,
	input wire pcf_pkg::pcf_cfg_t i_cfg,
	input wire logic i_block,
	input wire logic i_counter_clear,
	input wire pcf_pkg::pcf_status_t o_status
);
	localparam logic [7:0] DEB_MS [8] = '{8'h0A, 8'h14, 8'h1E, 8'h32, 8'h46, 8'h64, 8'h96, 8'h96};
	logic signed [31:0] lo, hi, inc;
	logic [31:0] since_q, stable_q, deb_min, rise_min, fall_min;
	logic prev_c_q;
	assign lo = (i_cfg.limit1 < i_cfg.limit2) ? i_cfg.limit1 : i_cfg.limit2;
	assign hi = (i_cfg.limit1 < i_cfg.limit2) ? i_cfg.limit2 : i_cfg.limit1;
	assign inc = i_cfg.adapt_en ? 32'(i_cfg.step_inc) : 32'sh0000_0001;
	assign deb_min = (32'(DEB_MS[i_cfg.debounce_sel]) - 32'h0000_0001) * TICK_CYCLES;
	assign rise_min = (32'(i_cfg.rise_hold) * 32'h0000_0064 - 32'h0000_0001) * TICK_CYCLES;
	assign fall_min = (32'(i_cfg.fall_hold) * 32'h0000_0064 - 32'h0000_0001) * TICK_CYCLES;
	////////////////////////////////////////////////////////////////////////////
	// cycles since the last event, and since the contact last moved
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			since_q <= 32'hFFFF_0000;
		end else if (o_status.rise_event || o_status.fall_event) begin
			since_q <= 32'h0000_0000;
		end else if (since_q != 32'hFFFF_FFFF) begin
			since_q <= since_q + 32'h0000_0001;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_c_q <= 1'b0;
			stable_q <= 32'h0000_0000;
		end else begin
			prev_c_q <= i_contact;
			stable_q <= (i_contact != prev_c_q) ? 32'h0000_0000 : stable_q + 32'h0000_0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_moved;
		$changed(o_status.count) && !$past(i_counter_clear) && !i_cfg.limit2_dflt;
	endsequence
	sequence s_event;
		o_status.rise_event || o_status.fall_event;
	endsequence
	a_block_gate: assert property (i_block && $past(i_block) && $past(i_block, 2)
		|-> !o_status.in_pulse) else $error("input pulse while blocked");
	a_edge_select: assert property (o_status.in_pulse |->
		($past(o_status.rise_event) && !(i_cfg.adapt_en && i_cfg.edge_sel == pcf_pkg::EDGE_FALL))
		|| ($past(o_status.fall_event) && i_cfg.adapt_en && i_cfg.edge_sel != pcf_pkg::EDGE_RISE))
		else $error("input pulse on an unselected edge");
	a_up_wrap: assert property (s_moved ##0 (inc > 0 && $past(o_status.count) + inc > hi)
		|-> o_status.count == lo) else $error("upward wrap missed the lower limit");
	a_down_wrap: assert property (s_moved ##0 (inc < 0 && $past(o_status.count) + inc < lo)
		|-> o_status.count == hi) else $error("downward wrap missed the upper limit");
	a_add_inc: assert property (s_moved ##0 ($past(o_status.count) + inc >= lo
		&& $past(o_status.count) + inc <= hi) |-> o_status.count == $past(o_status.count) + inc)
		else $error("counter step added the wrong amount");
	a_clear_load: assert property (i_counter_clear |=> o_status.count == i_cfg.limit1)
		else $error("clear did not load the first limit");
	a_deb_gap: assert property (s_event ##0 !i_cfg.min_sig_en
		|-> since_q + 32'h0000_0001 >= deb_min) else $error("edge taken inside debounce interval");
	a_hold_gap: assert property (s_event ##0 i_cfg.min_sig_en
		|-> stable_q >= (o_status.rise_event ? rise_min : fall_min))
		else $error("edge reported before its hold time");
endmodule
bind pcf_counter_channel pcf_counter_channel_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_contact(i_contact), .i_cfg(i_cfg),
	.i_block(i_block), .i_counter_clear(i_counter_clear), .o_status(o_status));

/* pcf_contact_model.sv */
// switched contact that chatters after each commanded change
`timescale 1ns/10ps
module pcf_contact_model (
	// clock
	input wire logic i_clock,
	// commanded level and chatter length
	input wire logic i_target,
	input wire logic [3:0] i_bounce,
	// contact line
	output logic o_contact
);
	logic want_q = 1'b0;
	logic last_q = 1'b0;
	logic [3:0] left_q = 4'h0;
	initial o_contact = 1'b0;
	// command taken on the rising edge, away from the bench's falling-edge writes
	always @(posedge i_clock) begin
		want_q <= i_target;
	end
	always @(negedge i_clock) begin
		if (want_q != last_q) begin
			last_q <= want_q;
			left_q <= i_bounce;
			o_contact <= want_q;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
			o_contact <= ~o_contact;
		end else begin
			o_contact <= last_q;
		end
	end
endmodule

/* tb_pcf_counter_channel.sv */
// self-checking bench for the pulse counter channel
`timescale 1ns/10ps
module tb_pcf_counter_channel;
	localparam logic [31:0] TICK = 32'h0000_0004;
	logic i_clock, i_rst_n, i_block, i_counter_clear, tgt, i_contact;
	logic [3:0] bnc;
	pcf_pkg::pcf_cfg_t cfg;
	pcf_pkg::pcf_status_t st;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int evn = 0;
	int stp = 0;
	pcf_counter_channel #(.TICK_CYCLES(TICK)) dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_contact(i_contact), .i_cfg(cfg), .i_block(i_block),
		.i_counter_clear(i_counter_clear), .o_status(st));
	pcf_contact_model model_u (.i_clock(i_clock), .i_target(tgt), .i_bounce(bnc),
		.o_contact(i_contact));
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (st.rise_event === 1'b1 || st.fall_event === 1'b1) evn <= evn + 1;
		if (st.step === 1'b1) stp <= stp + 1;
		if (cyc > 40000) begin
			failures++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			tgt = 1'b1;
			cycles(60);
			tgt = 1'b0;
			cycles(60);
		end
	endtask
	task automatic wait_ev(input int lim, output int n);
		int e0;
		e0 = evn;
		n = 0;
		while (evn == e0 && n < lim) begin
			@(negedge i_clock);
			n++;
		end
	endtask
	task automatic clr();
		i_counter_clear = 1'b1;
		cycles(1);
		i_counter_clear = 1'b0;
		cycles(2);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_debounce();
		logic [7:0] ms [7] = '{8'h0A, 8'h14, 8'h1E, 8'h32, 8'h46, 8'h64, 8'h96};
		int n;
		for (int s = 0; s < 7; s++) begin
			cfg.debounce_sel = 3'(s);
			bnc = 4'h6;
			tgt = 1'b1;
			wait_ev(20, n);
			chk(32'(n < 20), 32'h0000_0001);
			chk(32'(st.level), 32'h0000_0001);
			tgt = 1'b0;
			wait_ev(700, n);
			chk(32'(n + 4 >= (ms[s] - 1) * TICK && n <= ms[s] * TICK + 8), 32'h0000_0001);
			chk(32'(st.level), 32'h0000_0000);
			cycles(620);
		end
		cfg.debounce_sel = 3'h0;
		bnc = 4'h0;
	endtask
	task automatic t_hold();
		int n;
		cfg.min_sig_en = 1'b1;
		cfg.rise_hold = 16'h0001;
		cfg.fall_hold = 16'h0002;
		tgt = 1'b1;
		wait_ev(200, n);
		chk(n, 32'h0000_00C8);
		tgt = 1'b0;
		cycles(10);
		tgt = 1'b1;
		wait_ev(700, n);
		chk(32'(n >= 390 && n <= 420), 32'h0000_0001);
		tgt = 1'b0;
		wait_ev(1000, n);
		chk(32'(n >= 790 && n <= 820), 32'h0000_0001);
		tgt = 1'b1;
		cycles(300);
		tgt = 1'b0;
		wait_ev(1200, n);
		chk(n, 32'h0000_04B0);
		cfg.min_sig_en = 1'b0;
	endtask
	task automatic t_types();
		logic signed [31:0] hi [5] = '{32'sh0000_007F, 32'sh0000_00FF, 32'sh0000_7FFF,
			32'sh0000_FFFF, 32'sh7FFE_B940};
		logic signed [31:0] e;
		cfg.adapt_en = 1'b1;
		cfg.edge_sel = pcf_pkg::EDGE_RISE;
		cfg.step_inc = 15'h58F0;
		cfg.limit2_dflt = 1'b1;
		for (int t = 0; t < 5; t++) begin
			cfg.dtype = pcf_pkg::pcf_dtype_t'(t);
			clr();
			chk(st.count, 32'h0000_0000);
			pulses(1);
			chk(st.count, hi[t]);
			e = (hi[t] < 32'sh0000_2710) ? hi[t] : hi[t] - 32'sh0000_2710;
			pulses(1);
			chk(st.count, e);
		end
		cfg.limit2_dflt = 1'b0;
	endtask
	task automatic t_adapt();
		logic [31:0] want [3] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0006};
		int s0;
		cfg.dtype = pcf_pkg::DT_S32;
		cfg.step_inc = 15'h0001;
		for (int k = 0; k < 3; k++) begin
			cfg.edge_sel = pcf_pkg::pcf_edge_t'(k);
			clr();
			pulses(3);
			chk(st.count, want[k]);
		end
		cfg.pulses_per_step = 14'h0003;
		cfg.step_inc = 15'h0007;
		clr();
		s0 = stp;
		pulses(4);
		chk(st.count, 32'h0000_000E);
		chk(32'(stp - s0), 32'h0000_0002);
		i_block = 1'b1;
		pulses(2);
		chk(st.count, 32'h0000_000E);
		i_block = 1'b0;
		pulses(1);
		chk(st.count, 32'h0000_0015);
		cfg.adapt_en = 1'b0;
		clr();
		pulses(2);
		chk(st.count, 32'h0000_0002);
	endtask
	task automatic t_wrap();
		cfg.limit1 = 32'sh0000_000A;
		cfg.limit2 = 32'sh0000_0000;
		clr();
		chk(st.count, 32'h0000_000A);
		pulses(1);
		chk(st.count, 32'h0000_0000);
		pulses(10);
		chk(st.count, 32'h0000_000A);
		pulses(1);
		chk(st.count, 32'h0000_0000);
		cfg.adapt_en = 1'b1;
		cfg.edge_sel = pcf_pkg::EDGE_RISE;
		cfg.pulses_per_step = 14'h0001;
		cfg.step_inc = 15'h7FFD;
		pulses(2);
		chk(st.count, 32'h0000_0007);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rst_n = 1'b0;
		i_block = 1'b0;
		i_counter_clear = 1'b0;
		tgt = 1'b0;
		bnc = 4'h0;
		cfg = '0;
		cfg.rise_hold = 16'h000A;
		cfg.fall_hold = 16'h000A;
		cfg.pulses_per_step = 14'h0001;
		cfg.step_inc = 15'h0001;
		cfg.dtype = pcf_pkg::DT_S32;
		cfg.limit2 = 32'sh0000_03E8;
		cycles(3);
		i_rst_n = 1'b1;
		cycles(3);
		chk(st.count, 32'h0000_0000);
		t_debounce();
		t_hold();
		t_types();
		t_adapt();
		t_wrap();
		close_out();
	end
endmodule
